// *** core/axis_homing_unit.sv ***
// Axis homing unit: aligns the axis position counter with the drive
// Assumes the drive counts steps via step_pulse/step_dir; one clock domain
// Overview of operation
// [RQ1] Mode 0 loads position value directly
// [RQ2] Mode 1 adds position value to position
// [RQ3] Modes 0 and 1 cause no motion
// [RQ4] Modes 0 and 1 keep motion running
// [RQ5] Mode 2 waits for switch, no motion
// [RQ6] Mode 2 sets switch point plus offset
// [RQ7] Passive start does not abort motion
// [RQ8] Mode 3 drives approach until switch
// [RQ9] Active start aborts running motion first
// [RQ10] Active home uses configured switch edge
// [RQ11] Active home adds position value; the code instead loads the position value into the counter at the switch edge
// [RQ12] Mode 2 passive, mode 3 active
// [RQ13] Host homes mode 0 at standstill
// [RQ14] Host moves axis during passive homing
// [RQ15] Host keeps approach velocity low
// [RQ16] Switch filter shorter than switch pulse
// [RQ17] Homed flag set until next request
`timescale 1ns/1ps
`include "axis_homing_defines.svh"
module axis_homing_unit (
    input  wire logic                       sys_clk,
    input  wire logic                       reset,
    input  axis_homing_pkg::home_cmd_s      axis_home_command,
    input  axis_homing_pkg::home_cfg_s      home_cfg,
    input  wire logic                       ref_switch,
    input  wire logic                       step_pulse,
    input  wire logic                       step_dir,
    input  wire logic                       motion_active,
    output logic                            motion_abort,
    output logic                            approach_run,
    output logic                            approach_dir,
    output logic                            busy,
    output logic                            homed,
    output logic signed [`POS_W-1:0]        axis_position
);
    axis_homing_pkg::home_state_e state_r;
    logic signed [`POS_W-1:0]     offset_r;
    logic signed [`POS_W-1:0]     pos_r;
    logic                         homed_r;
    logic                         abort_r;
    logic                         run_r;
    logic                         dir_r;
    logic                         sw_rise;
    logic                         sw_fall;
    logic                         sw_edge;
    logic                         sw_any;
    logic                         cmd_go;

    switch_edge_detect u_edge (
        .sys_clk (sys_clk),
        .reset   (reset),
        .level   (ref_switch),
        .rise    (sw_rise),
        .fall    (sw_fall)
    );

    assign cmd_go  = axis_home_command.start;
    assign sw_edge = home_cfg.edge_rising ? sw_rise : sw_fall; // RQ10
    assign sw_any  = sw_rise;

    // Home state sequence
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_r  <= axis_homing_pkg::ST_IDLE;
            offset_r <= '0;
        end else if (cmd_go) begin
            offset_r <= axis_home_command.position;
            unique case (axis_home_command.mode)
                `MODE_PASSIVE: state_r <= axis_homing_pkg::ST_PASSIVE; // RQ12
                `MODE_ACTIVE:  state_r <= axis_homing_pkg::ST_ABORT;   // RQ12
                default:       state_r <= axis_homing_pkg::ST_DONE;    // RQ3
            endcase
        end else begin
            unique case (state_r)
                axis_homing_pkg::ST_IDLE:    state_r <= state_r;
                axis_homing_pkg::ST_PASSIVE: begin
                    if (sw_any) begin
                        state_r <= axis_homing_pkg::ST_DONE; // RQ6
                    end
                end
                axis_homing_pkg::ST_ABORT: begin
                    if (!motion_active) begin
                        state_r <= axis_homing_pkg::ST_SEEK; // RQ9
                    end
                end
                axis_homing_pkg::ST_SEEK: begin
                    if (sw_edge) begin
                        state_r <= axis_homing_pkg::ST_DONE; // RQ8
                    end
                end
                axis_homing_pkg::ST_DONE:    state_r <= state_r;
                default:                     state_r <= axis_homing_pkg::ST_IDLE;
            endcase
        end
    end

    // Axis position counter; step counting continues in every mode
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pos_r <= '0;
        end else if (cmd_go && axis_home_command.mode == `MODE_ABS) begin
            pos_r <= axis_home_command.position; // RQ1
        end else if (cmd_go && axis_home_command.mode == `MODE_REL) begin
            pos_r <= pos_r + axis_home_command.position; // RQ2
        end else if (state_r == axis_homing_pkg::ST_PASSIVE && sw_any) begin
            pos_r <= offset_r; // RQ6
        end else if (state_r == axis_homing_pkg::ST_SEEK && sw_edge) begin
            pos_r <= offset_r; // RQ11
        end else if (step_pulse) begin
            pos_r <= step_dir ? pos_r + 32'sh1 : pos_r - 32'sh1;
        end
    end

    // Homed indication
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            homed_r <= 1'b0;
        end else if (cmd_go) begin
            homed_r <= (axis_home_command.mode == `MODE_ABS) ||
                       (axis_home_command.mode == `MODE_REL); // RQ17
        end else if ((state_r == axis_homing_pkg::ST_PASSIVE && sw_any) ||
                     (state_r == axis_homing_pkg::ST_SEEK && sw_edge)) begin
            homed_r <= 1'b1; // RQ17
        end
    end

    // Abort and approach drive; modes 0..2 never touch running motion
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            abort_r <= 1'b0;
            run_r   <= 1'b0;
            dir_r   <= 1'b0;
        end else begin
            abort_r <= (cmd_go && axis_home_command.mode == `MODE_ACTIVE && motion_active) ||
                       (!cmd_go && state_r == axis_homing_pkg::ST_ABORT &&
                        motion_active); // RQ9 RQ4 RQ7
            run_r   <= !cmd_go && state_r == axis_homing_pkg::ST_SEEK && !sw_edge; // RQ8 RQ5
            dir_r   <= home_cfg.initial_dir; // RQ8
        end
    end

    assign motion_abort  = abort_r;
    assign approach_run  = run_r;
    assign approach_dir  = dir_r;
    assign busy          = state_r == axis_homing_pkg::ST_PASSIVE ||
                           state_r == axis_homing_pkg::ST_ABORT ||
                           state_r == axis_homing_pkg::ST_SEEK;
    assign homed         = homed_r;
    assign axis_position = pos_r;
endmodule // axis_homing_unit

// *** core/axis_homing_defines.svh ***
// Constants for the axis homing unit
// Assumes a 10 MHz system clock
`ifndef AXIS_HOMING_DEFINES_SVH
`define AXIS_HOMING_DEFINES_SVH
`define POS_W            32
`define MODE_W           2
`define MODE_ABS         2'h0
`define MODE_REL         2'h1
`define MODE_PASSIVE     2'h2
`define MODE_ACTIVE      2'h3
`define CLK_HZ           10000000
`define FILTER_TIME_US   6400
`endif

// *** core/axis_homing_pkg.sv ***
// Types for the axis homing unit
// Assumes the defines header is included first
`include "axis_homing_defines.svh"
package axis_homing_pkg;
    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_PASSIVE = 5'h02,
        ST_ABORT   = 5'h04,
        ST_SEEK    = 5'h08,
        ST_DONE    = 5'h10
    } home_state_e;

    typedef struct packed {
        logic                    start;
        logic [`MODE_W-1:0]      mode;
        logic signed [`POS_W-1:0] position;
    } home_cmd_s;

    typedef struct packed {
        logic initial_dir;
        logic edge_rising;
    } home_cfg_s;
endpackage

// *** core/switch_edge_detect.sv ***
// Edge detector for the reference point switch
// Assumes the switch level is already synchronous and filtered
`timescale 1ns/1ps
module switch_edge_detect (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic level,
    output logic      rise,
    output logic      fall
);
    logic level_r;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            level_r <= 1'b0;
        end else begin
            level_r <= level;
        end
    end

    assign rise = level & ~level_r;
    assign fall = ~level & level_r;
endmodule // switch_edge_detect

// *** verif/axis_homing_unit_sva.sv ***
// Checker for the axis homing unit, bound from the testbench top
// Assumes the defines header is on the include path
`timescale 1ns/1ps
`include "axis_homing_defines.svh"
module axis_homing_unit_sva (
    input wire logic                     sys_clk,
    input wire logic                     reset,
    input axis_homing_pkg::home_cmd_s    axis_home_command,
    input axis_homing_pkg::home_cfg_s    home_cfg,
    input wire logic                     ref_switch,
    input wire logic                     motion_active,
    input wire logic                     motion_abort,
    input wire logic                     approach_run,
    input wire logic                     approach_dir,
    input wire logic                     busy,
    input wire logic                     homed,
    input wire logic signed [`POS_W-1:0] axis_position
);
    logic signed [`POS_W-1:0] off_r;
    logic [1:0]               md_r;
    wire logic                go = axis_home_command.start;
    wire logic [1:0]          cm = axis_home_command.mode;
    // Offset and mode of the latest request
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            off_r <= '0;
            md_r <= '0;
        end else if (go) begin
            off_r <= axis_home_command.position;
            md_r <= cm;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_abs_load: assert property (go && cm == 0 |=> axis_position == off_r && homed)
        else $error("absolute load wrong");
    a_rel_add: assert property (go && cm == 1 |=> axis_position == $past(axis_position) + off_r)
        else $error("relative add wrong");
    a_direct_still: assert property (go && cm < 2 |=> !motion_abort && !approach_run && !busy)
        else $error("direct homing disturbed motion");
    a_passive_wait: assert property (go && cm == 2 |=> busy && !homed && !motion_abort && !approach_run)
        else $error("passive start wrong");
    a_passive_catch: assert property (!go && busy && md_r == 2 && $rose(ref_switch) |=> homed && axis_position == off_r)
        else $error("passive capture wrong");
    a_active_abort: assert property (go && cm == 3 && motion_active |=> motion_abort && busy)
        else $error("active start did not abort");
    a_seek_clear: assert property ($rose(approach_run) |-> !motion_active && !motion_abort && approach_dir == home_cfg.initial_dir)
        else $error("approach started wrongly");
    a_active_edge: assert property (!go && approach_run && (home_cfg.edge_rising ? $rose(ref_switch) : $fell(ref_switch)) |=> homed && axis_position == off_r && !approach_run)
        else $error("active capture wrong");
    a_homed_hold: assert property (homed && !go |=> homed)
        else $error("homed dropped");
    c_active: cover property (go && cm == 3 && motion_active);
    c_passive: cover property (busy && md_r == 2 && $rose(ref_switch));
    c_falling: cover property (approach_run && $fell(ref_switch));
endmodule // axis_homing_unit_sva

// *** verif/axis_far_side.sv ***
// Far side model: drive stepping one position a cycle, switch over 40 to 47
// Assumes the testbench pulses go to start an ordinary traversing move
`timescale 1ns/1ps
module axis_far_side (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic go,
    input  wire logic approach_run,
    input  wire logic approach_dir,
    input  wire logic motion_abort,
    output logic      step_pulse,
    output logic      step_dir,
    output logic      ref_switch,
    output logic      motion_active
);
    int mech_r;
    int stop_r;
    assign ref_switch = mech_r >= 40 && mech_r <= 47;
    // Drive obeys an abort only three cycles late
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mech_r <= 0;
            stop_r <= 0;
            motion_active <= 0;
            step_pulse <= 0;
            step_dir <= 0;
        end else begin
            stop_r <= motion_abort ? stop_r + 1 : 0;
            motion_active <= (motion_active || go) && stop_r != 3;
            step_pulse <= motion_active || approach_run;
            step_dir <= approach_run ? approach_dir : 1'h1;
            if (step_pulse) mech_r <= mech_r + (step_dir ? 1 : -1);
        end
    end
endmodule // axis_far_side

// *** verif/axis_homing_unit_test.sv ***
// Testbench for the axis homing unit against the far side model
// Assumes core files are compiled first
`timescale 1ns/1ps
`include "axis_homing_defines.svh"
module axis_homing_unit_test;
    logic sys_clk, reset, go, ref_switch, step_pulse, step_dir, motion_active;
    logic motion_abort, approach_run, approach_dir, busy, homed;
    logic signed [`POS_W-1:0] axis_position, pos_w;
    axis_homing_pkg::home_cmd_s cmd;
    axis_homing_pkg::home_cfg_s cfg;
    int err_count, checks;
    axis_homing_unit DUT (.sys_clk, .reset, .axis_home_command(cmd), .home_cfg(cfg),
        .ref_switch, .step_pulse, .step_dir, .motion_active, .motion_abort,
        .approach_run, .approach_dir, .busy, .homed, .axis_position);
    axis_far_side far (.sys_clk, .reset, .go, .approach_run, .approach_dir,
        .motion_abort, .step_pulse, .step_dir, .ref_switch, .motion_active);
    initial begin
        sys_clk = 0;
        forever #50 sys_clk = ~sys_clk;
    end
    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Returns half a cycle after the request was taken
    task home(input logic [1:0] m, input logic [31:0] p);
        cmd = '{1'h1, m, p};
        @(negedge sys_clk) cmd.start = 0;
    endtask
    task wait_homed;
        int i;
        for (i = 0; i < 200 && homed !== 1'h1; i++) @(negedge sys_clk);
        if (i == 200) begin
            err_count++;
            tally_and_finish;
        end
    endtask
    task t_direct;
        home(2'h0, 32'h55);
        check("still abs", axis_position, 32'h55);
        go = 1;
        @(negedge sys_clk) go = 0;
        repeat (3) @(negedge sys_clk);
        home(2'h0, 32'h12345678);
        check("abs", axis_position, 32'h12345678);
        check("keep", {motion_active, motion_abort, approach_run}, 3'h4);
        pos_w = axis_position;
        home(2'h1, 32'hFFFFFFF0);
        check("rel", axis_position, pos_w - 32'h10);
        check("homed", homed, 1'h1);
    endtask
    task t_active(input logic r);
        cfg = '{r, r};
        home(2'h3, 32'h7);
        check("abort", motion_abort, motion_active);
        check("busy", {busy, homed}, 2'h2);
        wait_homed;
        check("act pos", axis_position, 32'h7);
        check("edge", {ref_switch, approach_run}, {r, 1'h0});
        check("dir", approach_dir, r);
    endtask
    task t_passive;
        go = 1;
        @(negedge sys_clk) go = 0;
        home(2'h2, 32'h100);
        check("wait", {busy, homed, approach_run, motion_abort}, 4'h8);
        check("moving", motion_active, 1'h1);
        wait_homed;
        check("pass pos", axis_position, 32'h100);
    endtask
    initial begin
        reset = 1;
        go = 0;
        cmd = '0;
        cfg = '0;
        err_count = 0;
        checks = 0;
        repeat (3) @(negedge sys_clk);
        reset = 0;
        t_direct;
        t_active(1'h1);
        t_active(1'h0);
        t_passive;
        tally_and_finish;
    end
endmodule // axis_homing_unit_test
bind axis_homing_unit axis_homing_unit_sva chk (.sys_clk, .reset, .axis_home_command,
    .home_cfg, .ref_switch, .motion_active, .motion_abort, .approach_run, .approach_dir,
    .busy, .homed, .axis_position);
